// ===== hw/asq_top.v
// Converter sample sequencer control: four sequencers, result FIFOs,
// trigger arbitration, interrupts, averaging, Avalon-MM register slave.
// Assumes the analog converter is outside, clocked by REF_CLK.
//
// Functional notes
// - Four sequencers: eight, four, four, one deep.
// - Result word is 32 bits, low 10 used.
// - Each step has input and control nibbles.
// - Sequencer starts only while its enable set.
// - Same input in several steps is fine.
// - Any step may raise the raw interrupt.
// - FIFO is circular; each read pops oldest.
// - Pointers, full, empty visible; overflow, underflow logged.
// - Converter clock divided to about 16.667 MHz.
// - Mask bit gates interrupt to the controller.
// - Raw and masked interrupt views are readable.
// - Writing one clears a sequencer interrupt.
// - Priority value 0 served first, 3 last.
// - Trigger select includes software and always.
// - Software initiate bit starts processor-triggered sequencer.
// - Averaging accumulates up to 64 conversions.
// - Averaging off after reset, shared by all.
// - Single-ended results run 0x000 to 0x3ff.
// - Differential step selects pair 2k, 2k+1.
// - Differential zero difference reads 0x1ff.
// - Reset priorities: zero highest, three lowest.
`timescale 1ns/1ps
`include "asq_defines.vh"
module asq_top (
  // Clock, reset, enable
  input  wire        REF_CLK,
  input  wire        RST_B,
  input  wire        CE,
  // Avalon-MM slave
  input  wire [8:0]  AVS_ADDRESS,
  input  wire        AVS_READ,
  input  wire        AVS_WRITE,
  input  wire [31:0] AVS_WRITEDATA,
  input  wire [3:0]  AVS_BYTEENABLE,
  output reg  [31:0] AVS_READDATA,
  output reg         AVS_WAITREQUEST,
  // External trigger pins
  input  wire [3:0]  TRIG_IN,
  // Converter
  output reg         CONV_CLK,
  output reg         CONV_START,
  output reg  [3:0]  CONV_SEL,
  output reg         CONV_DIFF,
  output reg         CONV_TEMP,
  input  wire        CONV_DONE,
  input  wire [9:0]  CONV_DATA,
  // Per-sequencer interrupt lines
  output reg  [3:0]  IRQ_OUT
);
  // ********************************************************************
  // Functions
  // ********************************************************************
  function [3:0] cap;
    input [1:0] s;
    begin
      if (s == 2'h0)
        cap = `ASQ_CAP0;
      else if (s == 2'h3)
        cap = `ASQ_CAP3;
      else
        cap = `ASQ_CAP12;
    end
  endfunction

  function [31:0] merge;
    input [31:0] old;
    input [31:0] nw;
    input [3:0]  be;
    begin
      merge = (old & ~{{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}})
            | (nw & {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}});
    end
  endfunction

  function is_seq;
    input [8:0] a;
    begin
      is_seq = (a[8:5] >= `ASQ_SEQ_FIRST) && (a[8:5] <= `ASQ_SEQ_LAST);
    end
  endfunction

  // ********************************************************************
  // Reset release and converter clock divider
  // ********************************************************************
  reg rst_s1_reg;
  reg rst_s2_reg;
  always @(posedge REF_CLK or negedge RST_B) begin
    if (!RST_B) begin
      rst_s1_reg <= 1'b0;
      rst_s2_reg <= 1'b0;
    end else begin
      rst_s1_reg <= 1'b1;
      rst_s2_reg <= rst_s1_reg;
    end
  end
  wire rst_n = rst_s2_reg;

  reg  [1:0] div_reg;
  wire       tick = (div_reg == `ASQ_DIV - 1);
  always @(posedge REF_CLK or negedge rst_n) begin
    if (!rst_n) begin
      div_reg  <= 2'h0;
      CONV_CLK <= 1'b0;
    end else if (CE) begin
      div_reg  <= tick ? 2'h0 : div_reg + 2'h1;
      CONV_CLK <= tick;
    end
  end

  // ********************************************************************
  // Trigger pin synchronisers
  // ********************************************************************
  reg [3:0] trig_s1_reg;
  reg [3:0] trig_s2_reg;
  reg [3:0] trig_s3_reg;
  reg [3:0] trig_stable_reg;
  reg [3:0] trig_prev_reg;
  wire [3:0] trig_agree = ~(trig_s2_reg ^ trig_s3_reg);
  wire [3:0] trig_rise  = trig_stable_reg & ~trig_prev_reg;
  always @(posedge REF_CLK or negedge rst_n) begin
    if (!rst_n) begin
      trig_s1_reg     <= 4'h0;
      trig_s2_reg     <= 4'h0;
      trig_s3_reg     <= 4'h0;
      trig_stable_reg <= 4'h0;
      trig_prev_reg   <= 4'h0;
    end else if (CE) begin
      trig_s1_reg     <= TRIG_IN;
      trig_s2_reg     <= trig_s1_reg;
      trig_s3_reg     <= trig_s2_reg;
      trig_stable_reg <= (trig_s2_reg & trig_agree)
                       | (trig_stable_reg & ~trig_agree);
      trig_prev_reg   <= trig_stable_reg;
    end
  end

  // ********************************************************************
  // Register state
  // ********************************************************************
  reg [3:0]  active_reg;
  reg [3:0]  raw_reg;
  reg [3:0]  mask_reg;
  reg [3:0]  ovf_reg;
  reg [3:0]  unf_reg;
  reg [15:0] tsel_reg;
  reg [7:0]  prio_reg;
  reg [2:0]  avg_reg;
  reg [31:0] step_input_select [0:3];
  reg [31:0] step_control_nibbles [0:3];
  reg [9:0]  fifo_mem [0:31];
  reg [2:0]  head_reg [0:3];
  reg [2:0]  tail_reg [0:3];
  reg [3:0]  cnt_reg [0:3];
  reg        ack_reg;
  reg [3:0]  pend_reg;
  reg [2:0]  state_reg;
  reg [1:0]  cur_reg;
  reg [2:0]  step_reg;
  reg        done_reg;

  // The slave always inserts one wait cycle; writes and pops happen at
  // the edge where waitrequest is seen low, so each access acts once.
  wire        wr_go = AVS_WRITE & ack_reg;
  wire        rd_go = AVS_READ & ack_reg;
  wire [3:0]  a_blk = AVS_ADDRESS[8:5] - `ASQ_SEQ_FIRST;
  wire [1:0]  a_seq = a_blk[1:0];
  wire [4:0]  a_sub = AVS_ADDRESS[4:0];
  wire        a_ss  = is_seq(AVS_ADDRESS);
  wire        pop   = rd_go & a_ss & (a_sub == `ASQ_SUB_FIFO);
  wire [31:0] wd    = AVS_WRITEDATA;
  wire [31:0] tsel_wr = merge({16'h0, tsel_reg}, wd, AVS_BYTEENABLE);

  // ********************************************************************
  // Trigger events and arbitration
  // ********************************************************************
  reg [3:0] ev;
  reg [3:0] src;
  reg       found;
  reg [1:0] win;
  integer   i;
  integer   j;
  always @* begin
    ev    = 4'h0;
    src   = 4'h0;
    found = 1'b0;
    win   = 2'h0;
    for (i = 0; i < 4; i = i + 1) begin
      src = tsel_reg[4*i +: 4];
      if (src == `ASQ_SRC_PROC)
        ev[i] = wr_go && (AVS_ADDRESS == `ASQ_OFF_SOFT) && wd[i];
      else if (src == `ASQ_SRC_ALWAYS)
        ev[i] = 1'b1;
      else if (src <= `ASQ_SRC_EXT_HI)
        ev[i] = trig_rise[src[1:0] - 2'h1];
    end
    // Lowest priority value wins among pending enabled sequencers.
    for (j = 0; j < 4; j = j + 1)
      for (i = 0; i < 4; i = i + 1)
        if (!found && pend_reg[i] && active_reg[i]
            && (prio_reg[2*i +: 2] == j[1:0])) begin
          found = 1'b1;
          win   = i[1:0];
        end
  end

  // ********************************************************************
  // Sequencer step execution
  // ********************************************************************
  wire [3:0] sel_nib = step_input_select[cur_reg][4*step_reg +: 4];
  wire [3:0] ctl_nib = step_control_nibbles[cur_reg][4*step_reg +: 4];
  wire       avg_ok;
  wire [9:0] avg_data;
  wire       go       = CE & tick;
  wire       store    = go & (state_reg == `ASQ_ST_STORE);
  wire       full_cur = (cnt_reg[cur_reg] == cap(cur_reg));
  wire       seq_end  = ctl_nib[`ASQ_CTL_END]
                      || ({1'b0, step_reg} == cap(cur_reg) - 4'h1);
  wire       start    = go & (state_reg == `ASQ_ST_IDLE) & found;

  asq_avg u_avg (
    .clk       (REF_CLK),
    .rst_n     (rst_n),
    .ce        (CE),
    .shift     (avg_reg),
    .in_valid  (CONV_DONE & (state_reg == `ASQ_ST_WAIT)),
    .in_data   (CONV_DATA),
    .take      (store),
    .out_valid (avg_ok),
    .out_data  (avg_data)
  );

  always @(posedge REF_CLK or negedge rst_n) begin
    if (!rst_n) begin
      state_reg  <= `ASQ_ST_IDLE;
      cur_reg    <= 2'h0;
      step_reg   <= 3'h0;
      done_reg   <= 1'b0;
      pend_reg   <= 4'h0;
      CONV_START <= 1'b0;
      CONV_SEL   <= 4'h0;
      CONV_DIFF  <= 1'b0;
      CONV_TEMP  <= 1'b0;
    end else if (CE) begin
      // A new trigger outranks the clear of the one being started.
      pend_reg <= ((pend_reg & ~({3'h0, start} << win)) | ev)
                & active_reg;
      CONV_START <= 1'b0;
      if (CONV_DONE)
        done_reg <= 1'b1;
      if (tick) begin
        case (state_reg)
          `ASQ_ST_IDLE: begin
            if (found) begin
              cur_reg   <= win;
              step_reg  <= 3'h0;
              state_reg <= `ASQ_ST_CONV;
            end
          end
          `ASQ_ST_CONV: begin
            CONV_START <= 1'b1;
            CONV_DIFF  <= ctl_nib[`ASQ_CTL_DIFF];
            CONV_TEMP  <= ctl_nib[`ASQ_CTL_TEMP];
            CONV_SEL   <= ctl_nib[`ASQ_CTL_DIFF]
                        ? {sel_nib[2:0], 1'b0} : sel_nib;
            done_reg   <= 1'b0;
            state_reg  <= `ASQ_ST_WAIT;
          end
          `ASQ_ST_WAIT: begin
            if (avg_ok)
              state_reg <= `ASQ_ST_STORE;
            else if (done_reg)
              state_reg <= `ASQ_ST_CONV;
          end
          default: begin
            if (seq_end) begin
              state_reg <= `ASQ_ST_IDLE;
            end else begin
              step_reg  <= step_reg + 3'h1;
              state_reg <= `ASQ_ST_CONV;
            end
          end
        endcase
      end
    end
  end

  // ********************************************************************
  // Result FIFOs and register writes
  // ********************************************************************
  wire [4:0] wr_idx = {cur_reg, tail_reg[cur_reg]};
  integer    k;
  always @(posedge REF_CLK) begin
    if (CE && store && !full_cur)
      fifo_mem[wr_idx] <= avg_data;
  end

  always @(posedge REF_CLK or negedge rst_n) begin
    if (!rst_n) begin
      active_reg <= 4'h0;
      raw_reg    <= 4'h0;
      mask_reg   <= 4'h0;
      ovf_reg    <= 4'h0;
      unf_reg    <= 4'h0;
      tsel_reg   <= 16'h0000;
      prio_reg   <= `ASQ_PRIO_RST;
      avg_reg    <= 3'h0;
      for (k = 0; k < 4; k = k + 1) begin
        step_input_select[k] <= 32'h00000000;
        step_control_nibbles[k] <= (k == 3) ? `ASQ_CTL3_RST : 32'h0;
        head_reg[k] <= 3'h0;
        tail_reg[k] <= 3'h0;
        cnt_reg[k]  <= 4'h0;
      end
    end else if (CE) begin
      // Software writes first; hardware events below override clears.
      if (wr_go) begin
        if (AVS_ADDRESS == `ASQ_OFF_ACTIVE && AVS_BYTEENABLE[0])
          active_reg <= wd[3:0];
        else if (AVS_ADDRESS == `ASQ_OFF_MASK && AVS_BYTEENABLE[0])
          mask_reg <= wd[3:0];
        else if (AVS_ADDRESS == `ASQ_OFF_ISC && AVS_BYTEENABLE[0])
          raw_reg <= raw_reg & ~wd[3:0];
        else if (AVS_ADDRESS == `ASQ_OFF_OVF && AVS_BYTEENABLE[0])
          ovf_reg <= ovf_reg & ~wd[3:0];
        else if (AVS_ADDRESS == `ASQ_OFF_UNF && AVS_BYTEENABLE[0])
          unf_reg <= unf_reg & ~wd[3:0];
        else if (AVS_ADDRESS == `ASQ_OFF_TSEL)
          tsel_reg <= tsel_wr[15:0];
        else if (AVS_ADDRESS == `ASQ_OFF_PRIO) begin
          if (AVS_BYTEENABLE[0])
            prio_reg[3:0] <= {wd[5:4], wd[1:0]};
          if (AVS_BYTEENABLE[1])
            prio_reg[7:4] <= {wd[13:12], wd[9:8]};
        end else if (AVS_ADDRESS == `ASQ_OFF_AVG && AVS_BYTEENABLE[0])
          avg_reg <= (wd[2:0] > `ASQ_AVG_MAX) ? `ASQ_AVG_MAX : wd[2:0];
        else if (a_ss && a_sub == `ASQ_SUB_MUX)
          step_input_select[a_seq] <=
            merge(step_input_select[a_seq], wd, AVS_BYTEENABLE);
        else if (a_ss && a_sub == `ASQ_SUB_CTL)
          step_control_nibbles[a_seq] <=
            merge(step_control_nibbles[a_seq], wd, AVS_BYTEENABLE);
      end
      if (pop) begin
        if (cnt_reg[a_seq] == 4'h0) begin
          unf_reg[a_seq] <= 1'b1;
        end else begin
          head_reg[a_seq] <= ({1'b0, head_reg[a_seq]} == cap(a_seq) - 4'h1)
                           ? 3'h0 : head_reg[a_seq] + 3'h1;
        end
      end
      if (store) begin
        if (ctl_nib[`ASQ_CTL_IE])
          raw_reg[cur_reg] <= 1'b1;
        if (full_cur) begin
          ovf_reg[cur_reg] <= 1'b1;
        end else begin
          tail_reg[cur_reg] <= ({1'b0, tail_reg[cur_reg]}
                              == cap(cur_reg) - 4'h1)
                             ? 3'h0 : tail_reg[cur_reg] + 3'h1;
        end
      end
      for (k = 0; k < 4; k = k + 1)
        cnt_reg[k] <= cnt_reg[k]
          + ((store && !full_cur && cur_reg == k) ? 4'h1 : 4'h0)
          - ((pop && cnt_reg[k] != 4'h0 && a_seq == k) ? 4'h1 : 4'h0);
    end
  end

  // ********************************************************************
  // Read mux and bus handshake
  // ********************************************************************
  reg [31:0] rd_next;
  always @* begin
    rd_next = 32'h00000000;
    if (AVS_ADDRESS == `ASQ_OFF_ACTIVE)
      rd_next[3:0] = active_reg;
    else if (AVS_ADDRESS == `ASQ_OFF_RAW)
      rd_next[3:0] = raw_reg;
    else if (AVS_ADDRESS == `ASQ_OFF_MASK)
      rd_next[3:0] = mask_reg;
    else if (AVS_ADDRESS == `ASQ_OFF_ISC)
      rd_next[3:0] = raw_reg & mask_reg;
    else if (AVS_ADDRESS == `ASQ_OFF_OVF)
      rd_next[3:0] = ovf_reg;
    else if (AVS_ADDRESS == `ASQ_OFF_UNF)
      rd_next[3:0] = unf_reg;
    else if (AVS_ADDRESS == `ASQ_OFF_TSEL)
      rd_next[15:0] = tsel_reg;
    else if (AVS_ADDRESS == `ASQ_OFF_PRIO)
      rd_next = {18'h0, prio_reg[7:6], 2'h0, prio_reg[5:4], 2'h0,
                 prio_reg[3:2], 2'h0, prio_reg[1:0]};
    else if (AVS_ADDRESS == `ASQ_OFF_AVG)
      rd_next[2:0] = avg_reg;
    else if (a_ss && a_sub == `ASQ_SUB_MUX)
      rd_next = step_input_select[a_seq];
    else if (a_ss && a_sub == `ASQ_SUB_CTL)
      rd_next = step_control_nibbles[a_seq];
    else if (a_ss && a_sub == `ASQ_SUB_FIFO && cnt_reg[a_seq] != 4'h0)
      rd_next[9:0] = fifo_mem[{a_seq, head_reg[a_seq]}];
    else if (a_ss && a_sub == `ASQ_SUB_FSTAT) begin
      rd_next[2:0] = tail_reg[a_seq];
      rd_next[`ASQ_FST_HEAD +: 3] = head_reg[a_seq];
      rd_next[`ASQ_FST_EMPTY] = (cnt_reg[a_seq] == 4'h0);
      rd_next[`ASQ_FST_FULL]  = (cnt_reg[a_seq] == cap(a_seq));
    end
  end

  always @(posedge REF_CLK or negedge rst_n) begin
    if (!rst_n) begin
      ack_reg         <= 1'b0;
      AVS_WAITREQUEST <= 1'b1;
      AVS_READDATA    <= 32'h00000000;
      IRQ_OUT         <= 4'h0;
    end else if (CE) begin
      ack_reg         <= (AVS_READ | AVS_WRITE) & ~ack_reg;
      AVS_WAITREQUEST <= ~((AVS_READ | AVS_WRITE) & ~ack_reg);
      if (AVS_READ && !ack_reg)
        AVS_READDATA <= rd_next;
      IRQ_OUT <= raw_reg & mask_reg;
    end
  end
endmodule

// ===== hw/asq_defines.vh
// Constants of the converter sample sequencer: offsets, fields, resets.
// Assumes byte addressing on a 32-bit Avalon-MM slave port.
`ifndef ASQ_DEFINES_VH
`define ASQ_DEFINES_VH
// Register byte offsets.
`define ASQ_OFF_ACTIVE   9'h000
`define ASQ_OFF_RAW      9'h004
`define ASQ_OFF_MASK     9'h008
`define ASQ_OFF_ISC      9'h00c
`define ASQ_OFF_OVF      9'h010
`define ASQ_OFF_TSEL     9'h014
`define ASQ_OFF_UNF      9'h018
`define ASQ_OFF_PRIO     9'h020
`define ASQ_OFF_SOFT     9'h028
`define ASQ_OFF_AVG      9'h030
// Sequencer blocks sit at 0x040 + 0x020 * n; bits 8:5 of the address.
`define ASQ_SEQ_FIRST    4'h2
`define ASQ_SEQ_LAST     4'h5
`define ASQ_SUB_MUX      5'h00
`define ASQ_SUB_CTL      5'h04
`define ASQ_SUB_FIFO     5'h08
`define ASQ_SUB_FSTAT    5'h0c
// Reset values.
`define ASQ_PRIO_RST     8'he4
`define ASQ_CTL3_RST     32'h00000002
// Step control nibble fields.
`define ASQ_CTL_DIFF     0
`define ASQ_CTL_END      1
`define ASQ_CTL_IE       2
`define ASQ_CTL_TEMP     3
// FIFO status fields.
`define ASQ_FST_HEAD     4
`define ASQ_FST_EMPTY    8
`define ASQ_FST_FULL     12
// Trigger sources.
`define ASQ_SRC_PROC     4'h0
`define ASQ_SRC_EXT_LO   4'h1
`define ASQ_SRC_EXT_HI   4'h4
`define ASQ_SRC_ALWAYS   4'hf
// Averaging: log2 of sample count, at most 64 samples.
`define ASQ_AVG_MAX      3'h6
// Capacities.
`define ASQ_CAP0         4'h8
`define ASQ_CAP12        4'h4
`define ASQ_CAP3         4'h1
// Clock rates in kHz and the converter clock divider.
`define ASQ_REF_KHZ      50000
`define ASQ_TARGET_KHZ   16667
`define ASQ_DIV ((`ASQ_REF_KHZ + `ASQ_TARGET_KHZ - 1) / `ASQ_TARGET_KHZ)
// FSM states.
`define ASQ_ST_IDLE      3'h0
`define ASQ_ST_CONV      3'h1
`define ASQ_ST_WAIT      3'h2
`define ASQ_ST_STORE     3'h3
`endif

// ===== hw/asq_avg.v
// Hardware averaging of 2**shift conversions into one result.
// Assumes in_valid pulses once per finished conversion.
`timescale 1ns/1ps
`include "asq_defines.vh"
module asq_avg (
  // Clock and control
  input  wire       clk,
  input  wire       rst_n,
  input  wire       ce,
  input  wire [2:0] shift,
  // Samples in
  input  wire       in_valid,
  input  wire [9:0] in_data,
  // Average out
  input  wire       take,
  output reg        out_valid,
  output reg  [9:0] out_data
);
  reg  [15:0] acc_reg;
  reg  [6:0]  cnt_reg;
  wire [15:0] sum     = acc_reg + {6'h00, in_data};
  wire [15:0] shifted = sum >> shift;
  wire [6:0]  limit   = (7'h01 << shift) - 7'h01;
  wire        last    = (cnt_reg == limit);

  // With shift zero every sample is the last, so data passes straight.
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      acc_reg   <= 16'h0000;
      cnt_reg   <= 7'h00;
      out_valid <= 1'b0;
      out_data  <= 10'h000;
    end else if (ce) begin
      if (take)
        out_valid <= 1'b0;
      if (in_valid) begin
        if (last) begin
          out_valid <= 1'b1;
          out_data  <= shifted[9:0];
          acc_reg   <= 16'h0000;
          cnt_reg   <= 7'h00;
        end else begin
          acc_reg <= sum;
          cnt_reg <= cnt_reg + 7'h01;
        end
      end
    end
  end
endmodule

// ===== sim/asq_checker.sv
// Port assertions for the converter sample sequencer.
// Assumes CE is held high and that it is bound to asq_top.
`timescale 1ns/1ps
`include "asq_defines.vh"
module asq_checker (
  input wire        REF_CLK,
  input wire        RST_B,
  input wire [8:0]  AVS_ADDRESS,
  input wire        AVS_READ,
  input wire        AVS_WRITE,
  input wire [31:0] AVS_WRITEDATA,
  input wire [31:0] AVS_READDATA,
  input wire        AVS_WAITREQUEST,
  input wire        CONV_CLK,
  input wire        CONV_START,
  input wire [3:0]  CONV_SEL,
  input wire        CONV_DIFF,
  input wire        CONV_TEMP,
  input wire [3:0]  IRQ_OUT
);
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (!RST_B);
  wire wr_ok = AVS_WRITE && !AVS_WAITREQUEST;
  wire fifo_a = AVS_ADDRESS[4:0] == `ASQ_SUB_FIFO &&
                AVS_ADDRESS[8:5] >= `ASQ_SEQ_FIRST &&
                AVS_ADDRESS[8:5] <= `ASQ_SEQ_LAST;
  property p_tick;
    CONV_CLK |=> !CONV_CLK ##1 !CONV_CLK ##1 CONV_CLK;
  endproperty
  a_tick: assert property (p_tick)
    else $error("converter tick spacing wrong");
  property p_wait;
    (AVS_READ || AVS_WRITE) && AVS_WAITREQUEST |=> !AVS_WAITREQUEST;
  endproperty
  a_wait: assert property (p_wait)
    else $error("bus answer not after one wait cycle");
  property p_mask;
    wr_ok && AVS_ADDRESS == `ASQ_OFF_MASK && !AVS_WRITEDATA[0]
      |-> ##2 !IRQ_OUT[0];
  endproperty
  a_mask: assert property (p_mask)
    else $error("masked interrupt still forwarded");
  property p_clear;
    wr_ok && AVS_ADDRESS == `ASQ_OFF_ISC && AVS_WRITEDATA[0]
      |-> ##2 !IRQ_OUT[0];
  endproperty
  a_clear: assert property (p_clear)
    else $error("interrupt not cleared by write of one");
  property p_word;
    AVS_READ && !AVS_WAITREQUEST && fifo_a |-> AVS_READDATA[31:10] == 22'h0;
  endproperty
  a_word: assert property (p_word)
    else $error("result word upper bits not zero");
  property p_pair;
    CONV_START && CONV_DIFF |-> !CONV_SEL[0];
  endproperty
  a_pair: assert property (p_pair)
    else $error("differential step selects odd input");
  property p_hold;
    CONV_START |=> $stable({CONV_SEL, CONV_DIFF, CONV_TEMP}) [*2];
  endproperty
  a_hold: assert property (p_hold)
    else $error("step selection moved during conversion");
  property p_gap;
    CONV_START |=> !CONV_START [*3];
  endproperty
  a_gap: assert property (p_gap)
    else $error("conversions overlap");
endmodule
bind asq_top asq_checker u_chk (.REF_CLK(REF_CLK), .RST_B(RST_B),
  .AVS_ADDRESS(AVS_ADDRESS), .AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE),
  .AVS_WRITEDATA(AVS_WRITEDATA), .AVS_READDATA(AVS_READDATA),
  .AVS_WAITREQUEST(AVS_WAITREQUEST), .CONV_CLK(CONV_CLK),
  .CONV_START(CONV_START), .CONV_SEL(CONV_SEL), .CONV_DIFF(CONV_DIFF),
  .CONV_TEMP(CONV_TEMP), .IRQ_OUT(IRQ_OUT));

// ===== sim/asq_conv_model.sv
// Behavioural analog converter answering each start pulse.
// Assumes one start at a time; latency alternates short and long.
`timescale 1ns/1ps
module asq_conv_model (
  input  wire       clk,
  input  wire       conv_start,
  input  wire [3:0] conv_sel,
  input  wire       conv_diff,
  input  wire       conv_temp,
  output reg        conv_done,
  output reg  [9:0] conv_data
);
  reg [3:0] wait_cnt;
  reg       busy;
  reg       slow;
  initial begin
    conv_done = 1'b0;
    conv_data = 10'h0;
    wait_cnt = 4'h0;
    busy = 1'b0;
    slow = 1'b0;
  end
  always @(posedge clk) begin
    conv_done <= 1'b0;
    // Data is invalid outside the done cycle, so it must not linger.
    if (conv_done)
      conv_data <= ~conv_data;
    if (conv_start) begin
      busy <= 1'b1;
      wait_cnt <= slow ? 4'h6 : 4'h1;
      slow <= !slow;
    end else if (busy) begin
      if (wait_cnt == 4'h0) begin
        busy <= 1'b0;
        conv_done <= 1'b1;
        if (conv_diff)
          conv_data <= 10'h1ff;
        else if (conv_temp)
          conv_data <= 10'h2aa;
        else
          conv_data <= {conv_sel, conv_sel, conv_sel[1:0]};
      end else
        wait_cnt <= wait_cnt - 4'h1;
    end
  end
endmodule

// ===== sim/asq_top_bench.sv
// Self-checking bench for the sequencer through its register port.
// Assumes the converter model answers every start pulse.
`timescale 1ns/1ps
`include "asq_defines.vh"
module asq_top_bench;
  reg         ref_clk, rst_b, rd, wr;
  reg  [8:0]  addr;
  reg  [31:0] wdata, got;
  wire [31:0] rdata;
  wire        waitreq, conv_clk, conv_start, conv_diff, conv_temp, conv_done;
  wire [3:0]  conv_sel, irq;
  wire [9:0]  conv_data;
  integer     failures, cmp_count, cycles, i;
  reg  [3:0]  sel_q[$];
  reg  [3:0]  trig;
  asq_top DUT (.REF_CLK(ref_clk), .RST_B(rst_b), .CE(1'b1),
    .AVS_ADDRESS(addr), .AVS_READ(rd), .AVS_WRITE(wr), .AVS_WRITEDATA(wdata),
    .AVS_BYTEENABLE(4'hf), .AVS_READDATA(rdata), .AVS_WAITREQUEST(waitreq),
    .TRIG_IN(trig), .CONV_CLK(conv_clk), .CONV_START(conv_start),
    .CONV_SEL(conv_sel), .CONV_DIFF(conv_diff), .CONV_TEMP(conv_temp),
    .CONV_DONE(conv_done), .CONV_DATA(conv_data), .IRQ_OUT(irq));
  asq_conv_model u_conv (.clk(ref_clk), .conv_start(conv_start),
    .conv_sel(conv_sel), .conv_diff(conv_diff), .conv_temp(conv_temp),
    .conv_done(conv_done), .conv_data(conv_data));
  // ********************************
  // Bus tasks and comparison
  // ********************************
  function [31:0] ev(input [3:0] s);
    ev = {22'h0, s, s, s[1:0]};
  endfunction
  task bus(input [8:0] a, input w, input [31:0] d);
    begin
      @(posedge ref_clk);
      addr <= a;
      wdata <= d;
      wr <= w;
      rd <= !w;
      @(posedge ref_clk);
      while (waitreq !== 1'b0) @(posedge ref_clk);
      got = rdata;
      wr <= 1'b0;
      rd <= 1'b0;
    end
  endtask
  task chk(input [31:0] g, input [31:0] e);
    begin
      cmp_count = cmp_count + 1;
      if (g !== e) begin
        failures = failures + 1;
        $display("unexpected at %0t: got %h expected %h", $time, g, e);
      end
    end
  endtask
  task rdchk(input [8:0] a, input [31:0] e);
    begin
      bus(a, 1'b0, 32'h0);
      chk(got, e);
    end
  endtask
  task put(input [8:0] a, input [31:0] d);
    bus(a, 1'b1, d);
  endtask
  // Hangs are cut by the global cycle ceiling, not here.
  task poll(input [8:0] a, input [31:0] m, input [31:0] v);
    begin
      bus(a, 1'b0, 32'h0);
      while ((got & m) !== v) bus(a, 1'b0, 32'h0);
    end
  endtask
  task give_verdict;
    begin
      $display("comparisons %0d mismatches %0d", cmp_count, failures);
      if (failures == 0 && cmp_count > 0)
        $display("DONE - PASS");
      else
        $display("DONE - FAIL");
      $finish;
    end
  endtask
  // ********************************
  // Clock, monitor and scenarios
  // ********************************
  initial begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) begin
    cycles = cycles + 1;
    if (conv_start === 1'b1)
      sel_q.push_back(conv_sel);
    if (cycles == 30000) begin
      failures = failures + 1;
      give_verdict;
    end
  end
  initial begin
    rst_b = 1'b0;
    rd = 1'b0;
    wr = 1'b0;
    trig = 4'h0;
    addr = 9'h0;
    wdata = 32'h0;
    failures = 0;
    cmp_count = 0;
    cycles = 0;
    repeat (2) @(posedge ref_clk);
    rst_b <= 1'b1;
    repeat (3) @(posedge ref_clk);
    rdchk(`ASQ_OFF_PRIO, 32'h3210);
    rdchk(9'h0a4, 32'h2);
    rdchk(9'h04c, 32'h100);
    rdchk(`ASQ_OFF_AVG, 32'h0);
    rdchk(9'h100, 32'h0);
    // Four steps in an eight-step sequencer, one input used twice.
    put(9'h040, 32'h0000f353);
    put(9'h044, 32'h00006004);
    put(`ASQ_OFF_MASK, 32'h1);
    put(`ASQ_OFF_ACTIVE, 32'h1);
    put(`ASQ_OFF_SOFT, 32'h1);
    poll(9'h04c, 32'h7, 32'h4);
    chk({28'h0, irq}, 32'h1);
    rdchk(`ASQ_OFF_RAW, 32'h1);
    rdchk(`ASQ_OFF_ISC, 32'h1);
    rdchk(9'h04c, 32'h4);
    for (i = 0; i < 4; i = i + 1)
      rdchk(9'h048, ev(4'(32'hf353 >> (4 * i))));
    rdchk(9'h04c, 32'h144);
    rdchk(9'h048, 32'h0);
    rdchk(`ASQ_OFF_UNF, 32'h1);
    put(`ASQ_OFF_ISC, 32'h1);
    rdchk(`ASQ_OFF_RAW, 32'h0);
    chk({28'h0, irq}, 32'h0);
    // Masked run: raw view set, masked view and line stay low.
    put(`ASQ_OFF_MASK, 32'h0);
    put(`ASQ_OFF_SOFT, 32'h1);
    poll(9'h04c, 32'h107, 32'h0);
    rdchk(`ASQ_OFF_RAW, 32'h1);
    rdchk(`ASQ_OFF_ISC, 32'h0);
    chk({28'h0, irq}, 32'h0);
    for (i = 0; i < 4; i = i + 1)
      rdchk(9'h048, ev(4'(32'hf353 >> (4 * i))));
    put(`ASQ_OFF_ISC, 32'h1);
    put(`ASQ_OFF_UNF, 32'h1);
    rdchk(`ASQ_OFF_UNF, 32'h0);
    // Simultaneous soft triggers: priority value 0 is served first.
    put(`ASQ_OFF_PRIO, 32'h3012);
    put(9'h060, 32'h1);
    put(9'h064, 32'he);
    put(9'h080, 32'h2);
    put(9'h084, 32'h6);
    put(`ASQ_OFF_ACTIVE, 32'h7);
    sel_q.delete();
    put(`ASQ_OFF_SOFT, 32'h6);
    poll(`ASQ_OFF_RAW, 32'h6, 32'h6);
    chk({28'h0, sel_q[0]}, 32'h2);
    chk({28'h0, sel_q[1]}, 32'h1);
    rdchk(9'h068, 32'h2aa);
    // Averaging of four conversions makes one entry.
    put(`ASQ_OFF_ISC, 32'h6);
    put(`ASQ_OFF_AVG, 32'h2);
    sel_q.delete();
    put(`ASQ_OFF_SOFT, 32'h4);
    poll(`ASQ_OFF_RAW, 32'h4, 32'h4);
    chk(sel_q.size(), 32'h4);
    rdchk(9'h088, ev(4'h2));
    rdchk(9'h088, ev(4'h2));
    rdchk(9'h08c, 32'h122);
    put(`ASQ_OFF_AVG, 32'h0);
    // Always trigger on the one-deep sequencer, differential pair one.
    put(9'h0a0, 32'h1);
    put(9'h0a4, 32'h3);
    put(`ASQ_OFF_TSEL, 32'hf000);
    sel_q.delete();
    put(`ASQ_OFF_ACTIVE, 32'h8);
    poll(`ASQ_OFF_OVF, 32'h8, 32'h8);
    put(`ASQ_OFF_ACTIVE, 32'h0);
    chk({28'h0, sel_q[0]}, 32'h2);
    rdchk(9'h0a8, 32'h1ff);
    rdchk(`ASQ_OFF_ACTIVE, 32'h0);
    // Rising edge on the first trigger pin starts sequencer one.
    put(`ASQ_OFF_TSEL, 32'h0010);
    put(`ASQ_OFF_ACTIVE, 32'h2);
    trig <= 4'h1;
    poll(`ASQ_OFF_RAW, 32'h2, 32'h2);
    rdchk(9'h068, 32'h2aa);
    give_verdict;
  end
endmodule
